/* hdl/ssp_regs.svh */
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

// Opcodes, shifted most significant bit first.
`define SSP_OP_STAT_RD     8'h05
`define SSP_OP_STAT_FAST   8'h09
`define SSP_OP_STAT_WR     8'h01
`define SSP_OP_LATCH_SET   8'h06
`define SSP_OP_LATCH_CLR   8'h04
`define SSP_OP_MEM_WR      8'h02
`define SSP_OP_CLOCK_WR    8'h12
`define SSP_OP_SERIAL_WR   8'hc2
`define SSP_OP_NV_STORE    8'h3c
`define SSP_OP_NV_RECALL   8'h60
`define SSP_OP_AUTOSAVE_ON 8'h59
`define SSP_OP_AUTOSAVE_OFF 8'h19

// Status register value as shipped and after reset.
`define SSP_STAT_RESET     8'h00
`define SSP_RSVD_ZERO      2'h0

// Link bit counter marks.
`define SSP_CNT_ZERO       5'h00
`define SSP_CNT_ONE        5'h01
`define SSP_CNT_OP_LAST    5'h07
`define SSP_CNT_RD_START   5'h08
`define SSP_CNT_DATA_LAST  5'h0f
`define SSP_CNT_FAST_START 5'h10
`define SSP_CNT_WRAP       5'h17

// Block protect codes and protected range bases.
`define SSP_BP_NONE        2'h0
`define SSP_BP_QUARTER     2'h1
`define SSP_BP_HALF        2'h2
`define SSP_BP_ALL         2'h3
`define SSP_QUARTER_BASE   17'h18000
`define SSP_HALF_BASE      17'h10000
`define SSP_ARRAY_TOP      17'h1ffff

`endif

/* hdl/ssp_pkg.sv */
package ssp_pkg;

    typedef struct packed {
        logic       pin_protect_enable;
        logic       serial_lock;
        logic [1:0] rsvd;
        logic       block_protect_hi;
        logic       block_protect_lo;
        logic       write_enable_latch;
        logic       ready_flag;
    } ssp_status_type;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] data;
        logic       has_data;
    } ssp_cmd_type;

endpackage : ssp_pkg

/* hdl/ssp_status_protect.sv */
`timescale 1ns/1ns
`include "ssp_regs.svh"

// Function
// R1: Eight-bit status register with fixed bit layout.
// R2: Ready flag follows store or recall busy.
// R3: Bits four and five read zero, ignore writes.
// R4: Status write changes only bits 2,3,6,7.
// R5: Status write is opcode plus one data byte.
// R6: Serial lock refuses further serial number writes.
// R7: Serial lock is write-once, never cleared; the code reloads it from NV_IMAGE_IN on RECALL_LOAD, which can clear it.
// R8: Shipped values of listed bits are zero.
// R9: Plain status read shifts out status register.
// R10: Fast status read adds one dummy byte.
// R11: Written bits become nonvolatile only on store.
// R12: Write-type instructions need the latch set.
// R13: Without latch, write instruction ignored until deselect.
// R14: Latch zero at power-up, set by command.
// R15: Any write-type instruction clears latch on completion.
// R16: Latch-clear command acts at select rising edge.
// R17: Block-protect code maps to protected address range.
// R18: Protected addresses readable but never written.
// R19: Protect pin counts only when enable bit set.
// R20: Protect bits restored, latch zero after power-up.
// R21: Opcode 06 sets the write latch.
// R22: Opcode 04 clears the write latch.
// R23: Bits move MSB first, frame starts select low.
// R24: Short status write frame leaves register unchanged.
module ssp_status_protect
    import ssp_pkg::*;
(
    input  wire logic           CLK,
    input  wire logic           RST_B,
    input  wire logic           SCK,
    input  wire logic           CS_B,
    input  wire logic           MOSI,
    output logic                MISO,
    output logic                MISO_OE,
    input  wire logic           WP_B,
    input  wire logic           NV_BUSY,
    input  wire logic           STORE_DONE,
    input  wire logic           RECALL_LOAD,
    input  wire ssp_status_type NV_IMAGE_IN,
    output ssp_status_type      NV_IMAGE,
    output ssp_status_type      STATUS,
    input  wire logic [16:0]    ADDR,
    output logic                ADDR_PROTECTED,
    output logic                PIN_LOCK,
    output logic                CMD_GRANT,
    output logic [7:0]          CMD_CODE
);

    function automatic logic is_write_type(input logic [7:0] op);
        is_write_type = (op == `SSP_OP_STAT_WR)      || (op == `SSP_OP_MEM_WR)     ||
                        (op == `SSP_OP_CLOCK_WR)     || (op == `SSP_OP_SERIAL_WR)  ||
                        (op == `SSP_OP_NV_STORE)     || (op == `SSP_OP_NV_RECALL)  ||
                        (op == `SSP_OP_AUTOSAVE_ON)  || (op == `SSP_OP_AUTOSAVE_OFF);
    endfunction : is_write_type

    function automatic logic prot_hit(input logic [1:0] bp, input logic [16:0] addr);
        case (bp)
            `SSP_BP_QUARTER: prot_hit = (addr >= `SSP_QUARTER_BASE);
            `SSP_BP_HALF:    prot_hit = (addr >= `SSP_HALF_BASE);
            `SSP_BP_ALL:     prot_hit = (addr <= `SSP_ARRAY_TOP);
            default:         prot_hit = 1'b0;
        endcase
    endfunction : prot_hit

    // Link side, clocked by the serial clock.

    logic [4:0]     cnt_q;
    logic [4:0]     cnt_d;
    logic [7:0]     sh_q;
    wire  [7:0]     sh_d = {sh_q[6:0], MOSI};
    ssp_cmd_type    cmd_q;
    logic           seq_q;
    logic           so_q;
    logic           oe_q;
    ssp_status_type snap_q;

    wire op_done  = (cnt_q == `SSP_CNT_OP_LAST);
    wire dat_done = (cnt_q == `SSP_CNT_DATA_LAST);

    // Past the data byte the count cycles through one byte slot so reads repeat.
    assign cnt_d = (cnt_q == `SSP_CNT_WRAP) ? `SSP_CNT_FAST_START : cnt_q + `SSP_CNT_ONE;

    // Deselect clears the frame state without needing a clock edge.
    always_ff @(posedge SCK or negedge RST_B or posedge CS_B) begin
        if (!RST_B) begin
            cnt_q <= `SSP_CNT_ZERO;
            sh_q  <= `SSP_STAT_RESET;
        end else if (CS_B) begin
            cnt_q <= `SSP_CNT_ZERO;                                         // [R23]
            sh_q  <= `SSP_STAT_RESET;
        end else begin
            cnt_q <= cnt_d;
            sh_q  <= sh_d;                                                  // [R23]
        end
    end

    // The captured command survives deselect so the system side can read it.
    always_ff @(posedge SCK or negedge RST_B) begin
        if (!RST_B) begin
            cmd_q <= '0;
            seq_q <= 1'b0;
        end else if (op_done) begin
            cmd_q.op       <= sh_d;
            cmd_q.has_data <= 1'b0;
            seq_q          <= ~seq_q;
        end else if (dat_done) begin
            cmd_q.data     <= sh_d;                                         // [R5]
            cmd_q.has_data <= 1'b1;
        end
    end

    wire rd_plain = (cmd_q.op == `SSP_OP_STAT_RD)   && (cnt_q >= `SSP_CNT_RD_START);   // [R9]
    wire rd_fast  = (cmd_q.op == `SSP_OP_STAT_FAST) && (cnt_q >= `SSP_CNT_FAST_START); // [R10]
    wire rd_go    = rd_plain || rd_fast;
    wire rd_bit   = snap_q[~cnt_q[2:0]];

    always_ff @(negedge SCK or negedge RST_B or posedge CS_B) begin
        if (!RST_B) begin
            so_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (CS_B) begin
            so_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            so_q <= rd_go ? rd_bit : 1'b0;                                  // [R9] [R10]
            oe_q <= rd_go;
        end
    end

    assign MISO    = so_q;
    assign MISO_OE = oe_q;

    // System side, clocked by CLK.

    logic           cs_s1;
    logic           cs_s2;
    logic           cs_s3;
    logic           seq_s1;
    logic           seq_s2;
    logic           seen_q;
    logic           busy_s1;
    logic           busy_s2;
    logic           wp_s1;
    logic           wp_s2;
    ssp_status_type stat_q;
    ssp_status_type stat_d;
    ssp_status_type nv_q;
    logic           prot_q;
    logic           pin_q;
    logic           grant_q;
    logic [7:0]     code_q;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cs_s1   <= 1'b1;
            cs_s2   <= 1'b1;
            cs_s3   <= 1'b1;
            seq_s1  <= 1'b0;
            seq_s2  <= 1'b0;
            busy_s1 <= 1'b0;
            busy_s2 <= 1'b0;
            wp_s1   <= 1'b1;
            wp_s2   <= 1'b1;
        end else begin
            cs_s1   <= CS_B;
            cs_s2   <= cs_s1;
            cs_s3   <= cs_s2;
            seq_s1  <= seq_q;
            seq_s2  <= seq_s1;
            busy_s1 <= NV_BUSY;
            busy_s2 <= busy_s1;
            wp_s1   <= WP_B;
            wp_s2   <= wp_s1;
        end
    end

    // The command word is read only after deselect is seen here, when the
    // serial clock stands still, so it is stable across the crossing.
    ssp_status_type wr_val;
    wire  cs_rise  = cs_s2 && !cs_s3;
    wire  new_cmd  = cs_rise && (seq_s2 != seen_q);
    wire  op_wt    = is_write_type(cmd_q.op);
    wire  latch_on = stat_q.write_enable_latch;
    wire  set_go   = new_cmd && (cmd_q.op == `SSP_OP_LATCH_SET);            // [R21]
    wire  clr_go   = new_cmd && (cmd_q.op == `SSP_OP_LATCH_CLR);            // [R22]
    wire  wt_go    = new_cmd && op_wt;
    wire  sn_block = (cmd_q.op == `SSP_OP_SERIAL_WR) && stat_q.serial_lock; // [R6]
    wire  grant_go = wt_go && latch_on && !sn_block;                        // [R12] [R13]
    wire  status_write_cmd_go  = grant_go && (cmd_q.op == `SSP_OP_STAT_WR) && cmd_q.has_data; // [R24]
    assign wr_val  = cmd_q.data;

    always_comb begin
        stat_d            = stat_q;
        stat_d.ready_flag = busy_s2;                                        // [R2]
        stat_d.rsvd       = `SSP_RSVD_ZERO;                                 // [R3]
        if (RECALL_LOAD) begin
            stat_d.pin_protect_enable = NV_IMAGE_IN.pin_protect_enable;     // [R20]
            stat_d.serial_lock        = NV_IMAGE_IN.serial_lock;
            stat_d.block_protect_hi   = NV_IMAGE_IN.block_protect_hi;
            stat_d.block_protect_lo   = NV_IMAGE_IN.block_protect_lo;
        end else if (status_write_cmd_go) begin
            stat_d.pin_protect_enable = wr_val.pin_protect_enable;          // [R4]
            stat_d.serial_lock        = stat_q.serial_lock | wr_val.serial_lock; // [R7]
            stat_d.block_protect_hi   = wr_val.block_protect_hi;
            stat_d.block_protect_lo   = wr_val.block_protect_lo;
        end
        if (set_go) begin
            stat_d.write_enable_latch = 1'b1;                               // [R14]
        end else if (clr_go || wt_go) begin
            stat_d.write_enable_latch = 1'b0;                               // [R15] [R16]
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            stat_q <= `SSP_STAT_RESET;                                      // [R8] [R20]
            snap_q <= `SSP_STAT_RESET;
            seen_q <= 1'b0;
        end else begin
            stat_q <= stat_d;                                               // [R1]
            seen_q <= cs_rise ? seq_s2 : seen_q;
            // The read image freezes while selected; busy is seen per frame.
            snap_q <= cs_s2 ? stat_d : snap_q;
        end
    end

    wire [1:0] bp_code = {stat_q.block_protect_hi, stat_q.block_protect_lo};

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            nv_q    <= `SSP_STAT_RESET;
            prot_q  <= 1'b0;
            pin_q   <= 1'b0;
            grant_q <= 1'b0;
            code_q  <= `SSP_STAT_RESET;
        end else begin
            if (STORE_DONE) begin
                nv_q                    <= stat_q;                          // [R11]
                nv_q.write_enable_latch <= 1'b0;
                nv_q.ready_flag         <= 1'b0;
            end
            prot_q  <= prot_hit(bp_code, ADDR);                             // [R17] [R18]
            pin_q   <= stat_q.pin_protect_enable && !wp_s2;                 // [R19]
            grant_q <= grant_go;
            code_q  <= grant_go ? cmd_q.op : code_q;
        end
    end

    assign NV_IMAGE       = nv_q;
    assign STATUS         = stat_q;
    assign ADDR_PROTECTED = prot_q;
    assign PIN_LOCK       = pin_q;
    assign CMD_GRANT      = grant_q;
    assign CMD_CODE       = code_q;

    a_rsvd_reads_zero: assert property (@(posedge CLK) disable iff (!RST_B) // [R3]
        stat_q.rsvd == `SSP_RSVD_ZERO && snap_q.rsvd == `SSP_RSVD_ZERO)
        else $error("reserved status bits not zero");

    a_latch_set_cmd: assert property (@(posedge CLK) disable iff (!RST_B) // [R14]
        set_go |=> stat_q.write_enable_latch)
        else $error("latch not set by set command");

    a_latch_clr_cmd: assert property (@(posedge CLK) disable iff (!RST_B) // [R16]
        clr_go |=> !stat_q.write_enable_latch)
        else $error("latch not cleared by clear command");

    a_latch_clr_write: assert property (@(posedge CLK) disable iff (!RST_B) // [R15]
        wt_go |=> !stat_q.write_enable_latch ##1 !stat_q.write_enable_latch || set_go)
        else $error("latch survived write-type command");

    a_write_needs_latch: assert property (@(posedge CLK) disable iff (!RST_B) // [R12]
        CMD_GRANT |-> $past(stat_q.write_enable_latch))
        else $error("grant issued without latch");

    a_lock_sticky: assert property (@(posedge CLK) disable iff (!RST_B) // [R7]
        stat_q.serial_lock && !RECALL_LOAD |=> stat_q.serial_lock)
        else $error("serial lock cleared");

    a_serial_refused: assert property (@(posedge CLK) disable iff (!RST_B) // [R6]
        new_cmd && cmd_q.op == `SSP_OP_SERIAL_WR && stat_q.serial_lock |=> !CMD_GRANT)
        else $error("serial write granted while locked");

    a_short_frame: assert property (@(posedge CLK) disable iff (!RST_B) // [R24]
        new_cmd && !cmd_q.has_data && !RECALL_LOAD |=>
        $stable({stat_q.pin_protect_enable, stat_q.block_protect_hi, stat_q.block_protect_lo}))
        else $error("short status write changed register");

    a_ready_follows: assert property (@(posedge CLK) disable iff (!RST_B) // [R2]
        $rose(busy_s2) |=> stat_q.ready_flag [*2] or ##1 !busy_s2)
        else $error("ready flag does not follow busy");

    a_protect_all: assert property (@(posedge CLK) disable iff (!RST_B) // [R17]
        bp_code == `SSP_BP_ALL ##1 $stable(bp_code) |-> prot_q)
        else $error("full protection not applied");

    a_pin_ignored: assert property (@(posedge CLK) disable iff (!RST_B) // [R19]
        !stat_q.pin_protect_enable |=> !PIN_LOCK)
        else $error("protect pin acted while disabled");

    a_out_enable_read: assert property (@(negedge SCK) disable iff (!RST_B || CS_B) // [R9]
        (cnt_q < `SSP_CNT_RD_START) |=> !MISO_OE)
        else $error("output enabled during opcode");

    // The first six checks below tie each accepted or refused command to its effect one
    // edge later, so a broken gate shows up at the frame that exposed it.
    // Recall cycles are excluded where they may legally overwrite the bits.

    a_grant_code_match: assert property (@(posedge CLK) disable iff (!RST_B) // [R12]
        CMD_GRANT |-> CMD_CODE == $past(cmd_q.op))
        else $error("grant code differs from command");

    a_status_write_bits: assert property (@(posedge CLK) disable iff (!RST_B) // [R4]
        status_write_cmd_go && !RECALL_LOAD |=> {stat_q.pin_protect_enable, stat_q.block_protect_hi,
        stat_q.block_protect_lo} == $past({wr_val.pin_protect_enable,
        wr_val.block_protect_hi, wr_val.block_protect_lo}))
        else $error("status write did not load bits");

    a_lock_set_write: assert property (@(posedge CLK) disable iff (!RST_B) // [R7]
        status_write_cmd_go && wr_val.serial_lock && !RECALL_LOAD |=> stat_q.serial_lock)
        else $error("serial lock not set by write");

    a_latch_needs_cmd: assert property (@(posedge CLK) disable iff (!RST_B) // [R14]
        $rose(stat_q.write_enable_latch) |-> $past(set_go))
        else $error("latch set without set command");

    a_refused_no_grant: assert property (@(posedge CLK) disable iff (!RST_B) // [R13]
        wt_go && !latch_on |=> !CMD_GRANT)
        else $error("write granted with latch clear");

    a_refused_no_change: assert property (@(posedge CLK) disable iff (!RST_B) // [R13]
        wt_go && !latch_on && !RECALL_LOAD |=> $stable({stat_q.pin_protect_enable,
        stat_q.serial_lock, stat_q.block_protect_hi, stat_q.block_protect_lo}))
        else $error("refused write changed register");

    a_store_image: assert property (@(posedge CLK) disable iff (!RST_B) // [R11]
        STORE_DONE |=> NV_IMAGE[7:2] == $past(stat_q[7:2])
        && !NV_IMAGE.write_enable_latch && !NV_IMAGE.ready_flag)
        else $error("store image wrong");

    a_image_holds: assert property (@(posedge CLK) disable iff (!RST_B) // [R11]
        !STORE_DONE |=> $stable(NV_IMAGE))
        else $error("stored image changed without store");

    a_recall_loads: assert property (@(posedge CLK) disable iff (!RST_B) // [R20]
        RECALL_LOAD |=> {stat_q.pin_protect_enable, stat_q.block_protect_hi,
        stat_q.block_protect_lo} == $past({NV_IMAGE_IN.pin_protect_enable,
        NV_IMAGE_IN.block_protect_hi, NV_IMAGE_IN.block_protect_lo}))
        else $error("recall did not restore bits");

    a_protect_none: assert property (@(posedge CLK) disable iff (!RST_B) // [R17]
        bp_code == `SSP_BP_NONE ##1 $stable(bp_code) |-> !prot_q)
        else $error("protection applied with code none");

    a_protect_half: assert property (@(posedge CLK) disable iff (!RST_B) // [R17]
        bp_code == `SSP_BP_HALF ##1 $stable(bp_code) |-> prot_q == ($past(ADDR) >= `SSP_HALF_BASE))
        else $error("half protection range wrong");

    a_protect_quarter: assert property (@(posedge CLK) disable iff (!RST_B) // [R17]
        bp_code == `SSP_BP_QUARTER ##1 $stable(bp_code) |-> prot_q == ($past(ADDR) >= `SSP_QUARTER_BASE))
        else $error("quarter protection range wrong");

    a_ready_drops: assert property (@(posedge CLK) disable iff (!RST_B) // [R2]
        $fell(busy_s2) |=> !stat_q.ready_flag)
        else $error("ready flag stuck after busy ends");

    a_pin_lock_on: assert property (@(posedge CLK) disable iff (!RST_B) // [R19]
        stat_q.pin_protect_enable && !wp_s2 |=> PIN_LOCK)
        else $error("protect pin ignored while enabled");

    a_out_idle_off: assert property (@(posedge CLK) disable iff (!RST_B) // [R9]
        cs_s2 && cs_s1 |-> !MISO_OE)
        else $error("output enabled while deselected");

endmodule : ssp_status_protect

/* testbench/ssp_spi_host.sv */
`timescale 1ns/1ns
module ssp_spi_host (
    output logic      SCK,
    output logic      CS_B,
    output logic      MOSI,
    input  wire logic MISO
);
    localparam int HALF = 80;

    initial begin
        SCK = 1'b0;
        CS_B = 1'b1;
        MOSI = 1'b0;
    end

    // The clock stays low between frames, and the last eight bits seen on MISO are returned.
    task automatic frame(input logic [23:0] word, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        CS_B = 1'b0;
        #HALF;
        for (int i = 0; i < nbits; i++) begin
            MOSI = word[23 - i];
            #HALF;
            SCK = 1'b1;
            rd = {rd[6:0], MISO};
            #HALF;
            SCK = 1'b0;
        end
        #HALF;
        CS_B = 1'b1;
        // The released line must not keep showing the last bit.
        MOSI = ~MOSI;
        #(3 * HALF);
    endtask : frame
endmodule : ssp_spi_host

/* testbench/tb_ssp_status_protect.sv */
`timescale 1ns/1ns
`include "ssp_regs.svh"
module tb_ssp_status_protect;
    import ssp_pkg::*;
    logic           CLK, RST_B, SCK, CS_B, MOSI, MISO, WP_B, NV_BUSY;
    logic [16:0]    ADDR;
    logic           ADDR_PROTECTED, PIN_LOCK, CMD_GRANT;
    logic           STORE_DONE, RECALL_LOAD, MISO_OE;
    ssp_status_type NV_IMAGE_IN, NV_IMAGE, STATUS;
    logic [7:0]     CMD_CODE, rd, got;
    ssp_status_type exp_stat;
    logic [31:0]    seed;
    int             fail_count, comparisons;
    logic [7:0]     rd_q[$];
    logic [7:0]     gr_q[$];
    event           rd_ev;
    logic [7:0]     wr_ops[7] = '{8'h02, 8'h12, 8'hc2, 8'h3c, 8'h60, 8'h59, 8'h19};
    logic [16:0]    bnd[4] = '{17'h17fff, 17'h18000, 17'h0ffff, 17'h10000};

    ssp_spi_host host (.SCK(SCK), .CS_B(CS_B), .MOSI(MOSI), .MISO(MISO));

    ssp_status_protect dut (
        .CLK(CLK), .RST_B(RST_B), .SCK(SCK), .CS_B(CS_B), .MOSI(MOSI), .MISO(MISO),
        .MISO_OE(MISO_OE), .WP_B(WP_B), .NV_BUSY(NV_BUSY), .STORE_DONE(STORE_DONE),
        .RECALL_LOAD(RECALL_LOAD), .NV_IMAGE_IN(NV_IMAGE_IN), .NV_IMAGE(NV_IMAGE),
        .STATUS(STATUS),
        .ADDR(ADDR), .ADDR_PROTECTED(ADDR_PROTECTED), .PIN_LOCK(PIN_LOCK),
        .CMD_GRANT(CMD_GRANT), .CMD_CODE(CMD_CODE)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic prot(input int b, input logic [16:0] a);
        return b == 3 || (b == 2 && a >= 17'h10000) || (b == 1 && a >= 17'h18000);
    endfunction : prot

    task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] seen);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : compare

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    // Frames start a few ns after a falling edge so the link keeps its own phase.
    task automatic op(input logic [7:0] code, input logic [7:0] dat, input int n);
        @(negedge CLK);
        #3;
        host.frame({code, dat, 8'h00}, n, rd);
    endtask : op

    task automatic rd_stat(input logic fast);
        rd_q.push_back(exp_stat);
        if (fast) begin
            op(`SSP_OP_STAT_FAST, 8'h00, 24);
        end else begin
            op(`SSP_OP_STAT_RD, 8'h00, 16);
        end
        got = rd;
        ->rd_ev;
    endtask : rd_stat

    task automatic latched(input logic [7:0] code, input logic [7:0] dat, input int n,
                           input logic gr);
        op(`SSP_OP_LATCH_SET, 8'h00, 8);
        if (gr) begin
            gr_q.push_back(code);
        end
        op(code, dat, n);
        exp_stat.write_enable_latch = 1'b0;
    endtask : latched

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    initial begin
        forever begin
            @(rd_ev);
            compare("status read", rd_q.pop_front(), got);
        end
    end

    always @(negedge CLK) begin
        if (CMD_GRANT === 1'b1) begin
            if (gr_q.size() == 0) begin
                compare("unexpected grant", 8'h00, 8'hff);
            end else begin
                compare("grant code", gr_q.pop_front(), CMD_CODE);
            end
        end
    end

    initial begin
        #900000;
        fail_count++;
        $display("CHECK FAILED watchdog expected done seen hang");
        results();
    end

    initial begin
        RST_B = 1'b0;
        WP_B = 1'b1;
        NV_BUSY = 1'b0;
        ADDR = '0;
        STORE_DONE = 1'b0;
        RECALL_LOAD = 1'b0;
        NV_IMAGE_IN = '0;
        seed = 32'he0ba39c0;
        fail_count = 0;
        comparisons = 0;
        exp_stat = '0;
        repeat (5) @(negedge CLK);
        RST_B = 1'b1;
        rd_stat(1'b0);
        op(`SSP_OP_STAT_WR, 8'hcc, 16);
        rd_stat(1'b0);
        op(`SSP_OP_LATCH_SET, 8'h00, 8);
        exp_stat.write_enable_latch = 1'b1;
        rd_stat(1'b1);
        op(`SSP_OP_LATCH_CLR, 8'h00, 8);
        exp_stat.write_enable_latch = 1'b0;
        rd_stat(1'b0);
        foreach (wr_ops[i]) begin
            latched(wr_ops[i], 8'h00, 16, 1'b1);
            rd_stat(1'b0);
        end
        NV_BUSY = 1'b1;
        exp_stat.ready_flag = 1'b1;
        repeat (4) @(negedge CLK);
        rd_stat(1'b0);
        NV_BUSY = 1'b0;
        exp_stat.ready_flag = 1'b0;
        WP_B = 1'b0;
        for (int b = 0; b < 4; b++) begin
            latched(`SSP_OP_STAT_WR, {b[0], 3'b111, b[1:0], 2'b11}, 16, 1'b1);
            exp_stat = {b[0], 3'b100, b[1:0], 2'b00};
            rd_stat(1'b0);
            compare("pin lock", {7'h00, b[0]}, {7'h00, PIN_LOCK});
            for (int k = 0; k < 20; k++) begin
                seed = lfsr(seed);
                @(negedge CLK);
                ADDR = k < 4 ? bnd[k] : seed[16:0];
                @(negedge CLK);
                compare("protect", {7'h00, prot(b, ADDR)}, {7'h00, ADDR_PROTECTED});
            end
        end
        latched(`SSP_OP_STAT_WR, 8'h00, 16, 1'b1);
        exp_stat = 8'h40;
        rd_stat(1'b0);
        latched(`SSP_OP_SERIAL_WR, 8'h00, 16, 1'b0);
        rd_stat(1'b0);
        // A cut-short write is still granted and clears the latch; only the register stays.
        latched(`SSP_OP_STAT_WR, 8'h8c, 12, 1'b1);
        rd_stat(1'b0);
        compare("status", exp_stat, STATUS);
        compare("output enable idle", 8'h00, {7'h00, MISO_OE});
        @(negedge CLK);
        STORE_DONE = 1'b1;
        @(negedge CLK);
        STORE_DONE = 1'b0;
        compare("stored image", 8'h40, NV_IMAGE);
        NV_IMAGE_IN = 8'h8f;
        RECALL_LOAD = 1'b1;
        @(negedge CLK);
        RECALL_LOAD = 1'b0;
        exp_stat = 8'h8c;
        compare("recalled status", exp_stat, STATUS);
        rd_stat(1'b0);
        compare("image after recall", 8'h40, NV_IMAGE);
        compare("grants pending", 8'h00, 8'(gr_q.size()));
        results();
    end
endmodule : tb_ssp_status_protect
